// ===== agrc_afe_model.sv
`timescale 1ns/1ps
`default_nettype none
module agrc_afe_model (
	input  wire logic       clk_i,
	input  wire logic [3:0] rail_i,
	input  wire logic [1:0] low_i,
	output var  logic [3:0] rail_o = 4'h0,
	output var  logic [1:0] low_o = 2'h0
);
	// comparators move off the sampling edge, like a slow analog path
	always @(negedge clk_i) begin
		rail_o <= rail_i;
		low_o  <= low_i;
	end
endmodule
`default_nettype wire

// ===== agrc_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "agrc_map.vh"
module agrc_ctrl #(
	parameter CLK_MHZ = 200
) (
	input  wire       CLK_SYS_I,
	input  wire       RST_I,
	input  wire [7:0] ADDR_I,
	input  wire       WR_I,
	input  wire [7:0] WDATA_I,
	input  wire       RD_I,
	input  wire       POWER_DOWN_I,
	input  wire       CONVERTING_I,
	input  wire [3:0] RAIL_CMP_I,
	input  wire [1:0] REF_LOW_CMP_I,
	output reg  [7:0] RDATA_O,
	output reg        RDATA_VALID_O,
	output reg  [2:0] ANALOG_GAIN_O,
	output reg  [1:0] DIGITAL_SHIFT_O,
	output reg        AMP_POWER_O,
	output reg        AMP_BYPASS_O,
	output reg        AMP_HIGH_BIAS_O,
	output reg        RAIL_DETECT_EN_O,
	output reg  [1:0] REF_MUX_SEL_O,
	output reg        INT_REF_POWER_O,
	output reg        POS_REF_BUF_EN_O,
	output reg        NEG_REF_BUF_EN_O
);
// ------------------------------------------------------------
// synchronisers for analog comparator outputs, power-down and converting inputs
// ------------------------------------------------------------
reg [3:0] rail_s1_reg;
reg [3:0] rail_s2_reg;
reg [1:0] rlo_s1_reg;
reg [1:0] rlo_s2_reg;
reg       pd_s1_reg;
reg       pd_s2_reg;
reg       cv_s1_reg;
reg       cv_s2_reg;
always @(posedge CLK_SYS_I) begin
	if (RST_I) begin
		rail_s1_reg <= 4'h0;
		rail_s2_reg <= 4'h0;
		rlo_s1_reg  <= 2'h0;
		rlo_s2_reg  <= 2'h0;
		pd_s1_reg   <= 1'b0;
		pd_s2_reg   <= 1'b0;
		cv_s1_reg   <= 1'b0;
		cv_s2_reg   <= 1'b0;
	end else begin
		rail_s1_reg <= RAIL_CMP_I;
		rail_s2_reg <= rail_s1_reg;
		rlo_s1_reg  <= REF_LOW_CMP_I;
		rlo_s2_reg  <= rlo_s1_reg;
		pd_s1_reg   <= POWER_DOWN_I;
		pd_s2_reg   <= pd_s1_reg;
		cv_s1_reg   <= CONVERTING_I;
		cv_s2_reg   <= cv_s1_reg;
	end
end
// ------------------------------------------------------------
// configuration registers
// ------------------------------------------------------------
reg [7:0] gain_reg;
reg [7:0] ref_reg;
reg [7:0] exc1_reg;
reg [5:0] flags_reg;
reg [5:0] flags_next;
always @(posedge CLK_SYS_I) begin
	if (RST_I) begin
		gain_reg <= `AGRC_GAIN_RST;
		ref_reg  <= `AGRC_REF_RST;
		exc1_reg <= `AGRC_EXC1_RST;
	end else if (WR_I) begin
		case (ADDR_I)
		`AGRC_OFF_GAIN: gain_reg <= WDATA_I;
		`AGRC_OFF_REF:  ref_reg  <= WDATA_I;
		`AGRC_OFF_EXC1: exc1_reg <= WDATA_I;
		default: ;
		endcase
	end
end
wire [2:0] gain_code = gain_reg[`AGRC_GAIN_LSB+2:`AGRC_GAIN_LSB];
wire [1:0] amp_en    = gain_reg[`AGRC_AMPEN_LSB+1:`AGRC_AMPEN_LSB];
wire [1:0] refcon    = ref_reg[`AGRC_REFCON_LSB+1:`AGRC_REFCON_LSB];
wire [1:0] refsel    = ref_reg[`AGRC_REFSEL_LSB+1:`AGRC_REFSEL_LSB];
wire       rail_en   = exc1_reg[`AGRC_RAILEN_BIT];
// bypass honoured only at gain 1; otherwise amplifier stays in path
wire       bypass    = (amp_en == `AGRC_AMP_BYPASS) &&
                       (gain_code == 3'h0);
wire       hi_gain   = (gain_code > `AGRC_GAIN_32);
// ------------------------------------------------------------
// status flags: sticky, cleared by status read, set wins
// ------------------------------------------------------------
wire       st_rd     = RD_I && (ADDR_I == `AGRC_OFF_STATUS);
wire [5:0] flag_set;
assign flag_set[`AGRC_ST_REF1_BIT] = cv_s2_reg & rlo_s2_reg[1];
assign flag_set[`AGRC_ST_REF0_BIT] = cv_s2_reg & rlo_s2_reg[0];
// rail_s2 order: p_high, p_low, n_high, n_low
assign flag_set[`AGRC_ST_PHI_BIT]  = rail_en & ~bypass & rail_s2_reg[0];
assign flag_set[`AGRC_ST_PLO_BIT]  = rail_en & ~bypass & rail_s2_reg[1];
assign flag_set[`AGRC_ST_NHI_BIT]  = rail_en & ~bypass & rail_s2_reg[2];
assign flag_set[`AGRC_ST_NLO_BIT]  = rail_en & ~bypass & rail_s2_reg[3];
always @* begin
	flags_next = st_rd ? 6'h00 : flags_reg;
	flags_next = flags_next | flag_set;
end
always @(posedge CLK_SYS_I) begin
	if (RST_I)
		flags_reg <= 6'h00;
	else
		flags_reg <= flags_next;
end
// ------------------------------------------------------------
// read port and analog controls
// ------------------------------------------------------------
always @(posedge CLK_SYS_I) begin
	if (RST_I) begin
		RDATA_O          <= 8'h00;
		RDATA_VALID_O    <= 1'b0;
		ANALOG_GAIN_O    <= 3'h0;
		DIGITAL_SHIFT_O  <= 2'h0;
		AMP_POWER_O      <= 1'b0;
		AMP_BYPASS_O     <= 1'b1;
		AMP_HIGH_BIAS_O  <= 1'b0;
		RAIL_DETECT_EN_O <= 1'b0;
		REF_MUX_SEL_O    <= `AGRC_REFSEL_EXT0;
		INT_REF_POWER_O  <= 1'b0;
		POS_REF_BUF_EN_O <= 1'b1;
		NEG_REF_BUF_EN_O <= 1'b1;
	end else begin
		RDATA_VALID_O <= RD_I;
		case (ADDR_I)
		`AGRC_OFF_STATUS: RDATA_O <= {2'h0, flags_reg};
		`AGRC_OFF_GAIN:   RDATA_O <= gain_reg;
		`AGRC_OFF_REF:    RDATA_O <= ref_reg;
		`AGRC_OFF_EXC1:   RDATA_O <= exc1_reg;
		default:          RDATA_O <= 8'h00;
		endcase
		// gains above 32 stay analog 32; rest done digitally
		ANALOG_GAIN_O   <= hi_gain ? `AGRC_GAIN_32 : gain_code;
		DIGITAL_SHIFT_O <= hi_gain ? gain_code[1:0] - 2'h1 : 2'h0;
		AMP_POWER_O     <= ~bypass;
		AMP_BYPASS_O    <= bypass;
		AMP_HIGH_BIAS_O <= ~bypass & hi_gain;
		RAIL_DETECT_EN_O <= rail_en & ~bypass;
		// reserved select code 11 falls back to the first pair
		REF_MUX_SEL_O <= (refsel == 2'h3) ? `AGRC_REFSEL_EXT0
		                                  : refsel;
		INT_REF_POWER_O <= (refcon == `AGRC_REFCON_ON) ||
		                   ((refcon == `AGRC_REFCON_PD) &&
		                    ~pd_s2_reg);
		POS_REF_BUF_EN_O <= ~ref_reg[`AGRC_PBUF_BIT];
		NEG_REF_BUF_EN_O <= ~ref_reg[`AGRC_NBUF_BIT];
	end
end
endmodule
`default_nettype wire

// ===== agrc_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module agrc_ctrl_chk (
	input wire logic       CLK_SYS_I, RST_I, WR_I, RD_I, RDATA_VALID_O,
	input wire logic [7:0] ADDR_I, WDATA_I,
	input wire logic [2:0] ANALOG_GAIN_O,
	input wire logic [1:0] DIGITAL_SHIFT_O, REF_MUX_SEL_O,
	input wire logic       AMP_POWER_O, AMP_BYPASS_O, AMP_HIGH_BIAS_O,
	input wire logic       POS_REF_BUF_EN_O, NEG_REF_BUF_EN_O
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);
	// write lands in the register, then the output flop: two edges
	logic [7:0]      wd1_reg;
	logic [7:0]      wd2_reg;
	wire logic       g_w = WR_I && ADDR_I == 8'h03;
	wire logic       g_on = g_w && WDATA_I[4:3] == 2'h1;
	wire logic       r_w = WR_I && ADDR_I == 8'h05;
	wire logic [2:0] g = wd2_reg[2:0];
	always @(posedge CLK_SYS_I) begin
		wd1_reg <= WDATA_I;
		wd2_reg <= wd1_reg;
	end
	property p_gain; g_on |-> ##2
		ANALOG_GAIN_O == (g > 3'h5 ? 3'h5 : g); endproperty
	property p_shift; g_on |-> ##2
		DIGITAL_SHIFT_O == (g > 3'h5 ? g[1:0] - 2'h1 : 2'h0); endproperty
	property p_bias; g_on |-> ##2 AMP_HIGH_BIAS_O == (g > 3'h5); endproperty
	property p_on; g_on |-> ##2 AMP_POWER_O && !AMP_BYPASS_O; endproperty
	property p_byp; g_w && WDATA_I[4:0] == 5'h00 |-> ##2
		!AMP_POWER_O && AMP_BYPASS_O; endproperty
	property p_mux; r_w && WDATA_I[3:2] != 2'h3 |-> ##2
		REF_MUX_SEL_O == wd2_reg[3:2]; endproperty
	property p_buf; r_w |-> ##2 POS_REF_BUF_EN_O == !wd2_reg[5]
		&& NEG_REF_BUF_EN_O == !wd2_reg[4]; endproperty
	property p_rd; RD_I |=> RDATA_VALID_O; endproperty
	a_gain: assert property (p_gain) else $error("gain");
	a_shift: assert property (p_shift) else $error("shift");
	a_bias: assert property (p_bias) else $error("bias");
	a_on: assert property (p_on) else $error("amp on");
	a_byp: assert property (p_byp) else $error("bypass");
	a_mux: assert property (p_mux) else $error("ref mux");
	a_buf: assert property (p_buf) else $error("buffers");
	a_rd: assert property (p_rd) else $error("read valid");
	c_g7: cover property (g_on && WDATA_I[2:0] == 3'h7);
	c_int: cover property (REF_MUX_SEL_O == 2'h2);
	c_byp: cover property (AMP_BYPASS_O && $past(!AMP_BYPASS_O));
endmodule
bind agrc_ctrl agrc_ctrl_chk chk (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
	.WR_I(WR_I), .RD_I(RD_I), .RDATA_VALID_O(RDATA_VALID_O), .ADDR_I(ADDR_I),
	.WDATA_I(WDATA_I), .ANALOG_GAIN_O(ANALOG_GAIN_O),
	.DIGITAL_SHIFT_O(DIGITAL_SHIFT_O), .REF_MUX_SEL_O(REF_MUX_SEL_O),
	.AMP_POWER_O(AMP_POWER_O), .AMP_BYPASS_O(AMP_BYPASS_O),
	.AMP_HIGH_BIAS_O(AMP_HIGH_BIAS_O), .POS_REF_BUF_EN_O(POS_REF_BUF_EN_O),
	.NEG_REF_BUF_EN_O(NEG_REF_BUF_EN_O));
`default_nettype wire

// ===== agrc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module agrc_ctrl_tb;
	logic clk = 0, rst = 1, wr = 0, rd = 0, pd = 0, conv = 0;
	logic [7:0] addr = 8'h00, wd = 8'h00, rdat;
	logic [3:0] rail = 4'h0, rail_c;
	logic [1:0] low = 2'h0, low_c, gs, mux;
	logic [2:0] ga;
	logic vld, pw, byp, hb, ren, ir, pb, nb;
	int err_total = 0, checked = 0, cyc = 0;
	initial forever #2.5 clk = ~clk;
	agrc_afe_model afe (.clk_i(clk), .rail_i(rail), .low_i(low),
		.rail_o(rail_c), .low_o(low_c));
	agrc_ctrl dut (.CLK_SYS_I(clk), .RST_I(rst), .ADDR_I(addr), .WR_I(wr),
		.WDATA_I(wd), .RD_I(rd), .POWER_DOWN_I(pd), .CONVERTING_I(conv),
		.RAIL_CMP_I(rail_c), .REF_LOW_CMP_I(low_c), .RDATA_O(rdat),
		.RDATA_VALID_O(vld), .ANALOG_GAIN_O(ga), .DIGITAL_SHIFT_O(gs),
		.AMP_POWER_O(pw), .AMP_BYPASS_O(byp), .AMP_HIGH_BIAS_O(hb),
		.RAIL_DETECT_EN_O(ren), .REF_MUX_SEL_O(mux), .INT_REF_POWER_O(ir),
		.POS_REF_BUF_EN_O(pb), .NEG_REF_BUF_EN_O(nb));
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	// write ends one and a half cycles after the taking edge so outputs have landed
	task automatic wr8(logic [7:0] a, logic [7:0] d);
		@(negedge clk);
		addr = a;
		wd = d;
		wr = 1;
		@(negedge clk);
		wr = 0;
		@(negedge clk);
	endtask
	task automatic rd8(string n, logic [7:0] a, logic [7:0] e);
		@(negedge clk);
		addr = a;
		rd = 1;
		@(negedge clk);
		rd = 0;
		chk("valid", {7'h0, vld}, 8'h01);
		chk(n, rdat, e);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			tally_and_finish();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(negedge clk);
		rst = 0;
		chk("reset", {pw, byp, mux, pb, nb, ir, hb}, 8'h4c);
		for (int a = 2; a < 7; a++) rd8("rst", 8'(a), 8'h00);
		for (int g = 0; g < 8; g++) begin
			wr8(8'h03, 8'(8 + g));
			chk("amp", {ga, gs, hb, pw, byp}, g > 5 ? {3'h5, 2'(g - 5), 3'h6}
				: {3'(g), 5'h02});
			rd8("gain", 8'h03, 8'(8 + g));
		end
		wr8(8'h03, 8'h03);
		chk("nobyp", {pw, byp}, 8'h02);
		wr8(8'h03, 8'h00);
		chk("byp", {pw, byp}, 8'h01);
		for (int s = 0; s < 3; s++) begin
			wr8(8'h05, 8'(s * 4 + 2));
			chk("ref", {mux, ir, pb, nb}, 8'(s * 8 + 7));
		end
		wr8(8'h05, 8'h39);
		pd = 1;
		repeat (5) @(negedge clk);
		chk("pd", {mux, ir, pb, nb}, 8'h10);
		pd = 0;
		repeat (5) @(negedge clk);
		chk("wake", {7'h0, ir}, 8'h01);
		wr8(8'h03, 8'h08);
		wr8(8'h06, 8'h80);
		chk("ren", {7'h0, ren}, 8'h01);
		rail = 4'h5;
		repeat (5) @(negedge clk);
		rail = 4'h0;
		repeat (5) @(negedge clk);
		rd8("rail", 8'h01, 8'h28);
		rd8("clr", 8'h01, 8'h00);
		wr8(8'h06, 8'h00);
		rail = 4'hf;
		repeat (5) @(negedge clk);
		rd8("off", 8'h01, 8'h00);
		rail = 4'h0;
		conv = 1;
		low = 2'h3;
		repeat (5) @(negedge clk);
		low = 2'h0;
		repeat (5) @(negedge clk);
		rd8("reflow", 8'h01, 8'h03);
		tally_and_finish();
	end
endmodule
`default_nettype wire

// ===== agrc_map.vh
`ifndef AGRC_MAP_VH
`define AGRC_MAP_VH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define AGRC_OFF_STATUS   8'h01
`define AGRC_OFF_GAIN     8'h03
`define AGRC_OFF_REF      8'h05
`define AGRC_OFF_EXC1     8'h06
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define AGRC_GAIN_LSB     0
`define AGRC_AMPEN_LSB    3
`define AGRC_REFCON_LSB   0
`define AGRC_REFSEL_LSB   2
`define AGRC_NBUF_BIT     4
`define AGRC_PBUF_BIT     5
`define AGRC_RAILEN_BIT   7
`define AGRC_ST_REF1_BIT  0
`define AGRC_ST_REF0_BIT  1
`define AGRC_ST_NLO_BIT   2
`define AGRC_ST_NHI_BIT   3
`define AGRC_ST_PLO_BIT   4
`define AGRC_ST_PHI_BIT   5
// ------------------------------------------------------------
// reset values and codes
// ------------------------------------------------------------
`define AGRC_GAIN_RST     8'h00
`define AGRC_REF_RST      8'h00
`define AGRC_EXC1_RST     8'h00
`define AGRC_AMP_BYPASS   2'h0
`define AGRC_AMP_ON       2'h1
`define AGRC_REFSEL_EXT0  2'h0
`define AGRC_REFSEL_EXT1  2'h1
`define AGRC_REFSEL_INT   2'h2
`define AGRC_REFCON_OFF   2'h0
`define AGRC_REFCON_PD    2'h1
`define AGRC_REFCON_ON    2'h2
`define AGRC_GAIN_32      3'h5
`endif
